/* rtl/sfr_page_params.svh */
// Offsets, field positions, reset values and page codes of the paging block.
`ifndef SFR_PAGE_PARAMS_SVH
`define SFR_PAGE_PARAMS_SVH
`define SFR_SPACE_BASE      8'h80
`define ADDR_ACTIVE_PAGE    8'ha7
`define ADDR_STACK_SECOND   8'h85
`define ADDR_STACK_BOTTOM   8'h86
`define ADDR_PAGE_CONTROL   8'h8e
`define PAGE_ZERO           8'h00
`define PAGE_TWO            8'h02
`define PAGE_FIFTEEN        8'h0f
`define PAGE_RESET          8'h00
`define CONTROL_RESET       8'h01
`define AUTO_ENABLE_BIT     0
`define BIT_NIBBLE_A        4'h0
`define BIT_NIBBLE_B        4'h8
`endif

/* rtl/sfr_page_pkg.sv */
// Types shared by the paging block.
package sfr_page_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    PG_NONE    = 2'b00,
    PG_ZERO    = 2'b01,
    PG_TWO     = 2'b10,
    PG_FIFTEEN = 2'b11
  } page_sel_t;
endpackage : sfr_page_pkg

/* rtl/sfr_access_decode.sv */
// Decode of a direct access into the special function register space.
`include "sfr_page_params.svh"
module sfr_access_decode (
  input  wire logic                    directAddrValid,
  input  wire logic [7:0]              directAddr,
  input  wire logic                    bitAccess,
  input  wire sfr_page_pkg::byte_t     pageValue,
  output logic                         sfrHit,
  output logic                         bitAllowed,
  output sfr_page_pkg::page_sel_t      pageSel
);
  import sfr_page_pkg::*;

  always_comb begin
    sfrHit     = directAddrValid && directAddr[7];  // R1
    bitAllowed = (directAddr[3:0] == `BIT_NIBBLE_A)
              || (directAddr[3:0] == `BIT_NIBBLE_B)
              || !bitAccess;  // R2
    unique case (pageValue)  // R5
      `PAGE_ZERO:    pageSel = PG_ZERO;
      `PAGE_TWO:     pageSel = PG_TWO;
      `PAGE_FIFTEEN: pageSel = PG_FIFTEEN;
      default:       pageSel = PG_NONE;
    endcase
  end
endmodule : sfr_access_decode

/* rtl/sfr_page_select_and_stack.sv */
// Page select register, three-entry page stack and page steering for direct accesses.
//
// Overview of operation
// R1 - Direct accesses 0x80-0xFF go to register space.
// R2 - Nibble 0 or 8 addresses allow bit access.
// R3 - Software avoids unoccupied register locations.
// R4 - Eight-bit page value selects register page.
// R5 - Only pages zero, two, fifteen implemented.
// R6 - Software selects page before paged access.
// R7 - Interrupt entry pushes page onto stack.
// R8 - Interrupt return reloads page from second.
// R9 - Pop moves bottom into second entry.
// R10 - Stack writes change values, never push/pop.
// R11 - Service routines set page themselves.
// R12 - Auto-paging enable bit resets to one.
// R13 - Enable clear: no save, no restore.
// R14 - Enable set: save and restore page.
// R15 - Control upper seven bits read zero.
// R16 - All-page registers respond on any page.
// R17 - Page and stack registers reset zero.
// R18 - Page reads current, writes without stack.
// R19 - Push on vector accept, pop on return.
`include "sfr_page_params.svh"
module sfr_page_select_and_stack (
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  input  wire logic                    directAddrValid,
  input  wire logic [7:0]              directAddr,
  input  wire logic                    directWrite,
  input  wire logic                    bitAccess,
  input  wire logic [2:0]              bitIndex,
  input  wire logic                    bitValue,
  input  wire sfr_page_pkg::byte_t     writeData,
  input  wire logic                    vectorAccept,
  input  wire logic                    interruptReturnDone,
  output sfr_page_pkg::byte_t          readData,
  output logic                         sfrSelect,
  output logic                         pageZeroSelect,
  output logic                         pageTwoSelect,
  output logic                         pageFifteenSelect,
  output logic                         accessRefused,
  output sfr_page_pkg::byte_t          activePageSelect,
  output logic                         autoPageEnable
);
  import sfr_page_pkg::*;

  byte_t      pageStackSecond_ff;
  byte_t      pageStackBottom_ff;
  logic       sfrHit;
  logic       bitAllowed;
  page_sel_t  pageSel;
  logic       writeStrobe;
  byte_t      currentValue;
  byte_t      nxt_value;
  byte_t      nxt_readData;
  logic       pushEvent;
  logic       popEvent;
  // Write strobes of the registers owned here, then the control visibility and legal access terms.
  logic       writePage;
  logic       writeSecond;
  logic       writeBottom;
  logic       writeControl;
  logic       controlVisible;
  logic       legalAccess;

  // The reset byte is named so that its enable bit can be picked out of it.
  localparam byte_t ControlReset = `CONTROL_RESET;

  ////////////////////////////////////////////////////////////////////////////////

  // The decode sees the page register itself, so a page write steers the next access.
  sfr_access_decode u_decode (
    .directAddrValid (directAddrValid),
    .directAddr      (directAddr),
    .bitAccess       (bitAccess),
    .pageValue       (activePageSelect),
    .sfrHit          (sfrHit),
    .bitAllowed      (bitAllowed),
    .pageSel         (pageSel)
  );

  ////////////////////////////////////////////////////////////////////////////////

  // Bit access is a read-modify-write of the addressed byte.
  function automatic byte_t merge_bit(byte_t cur, logic [2:0] idx, logic val);
    byte_t r;
    r      = cur;
    r[idx] = val;
    return r;
  endfunction : merge_bit

  // The stack and page registers answer on every page, so they skip the page decode.
  function automatic logic all_page_reg(byte_t addr);
    return addr == `ADDR_ACTIVE_PAGE || addr == `ADDR_STACK_SECOND
        || addr == `ADDR_STACK_BOTTOM;
  endfunction : all_page_reg

  // Bit writes merge into the byte that the address holds now.
  always_comb begin
    unique case (directAddr)  // R16
      `ADDR_ACTIVE_PAGE:  currentValue = activePageSelect;
      `ADDR_STACK_SECOND: currentValue = pageStackSecond_ff;
      `ADDR_STACK_BOTTOM: currentValue = pageStackBottom_ff;
      default:            currentValue = {7'h00, autoPageEnable};  // R15
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////

  assign nxt_value      = bitAccess ? merge_bit(currentValue, bitIndex, bitValue) : writeData;
  assign writeStrobe    = sfrHit && directWrite && bitAllowed;  // R2
  assign writePage      = writeStrobe && directAddr == `ADDR_ACTIVE_PAGE;  // R18
  assign writeSecond    = writeStrobe && directAddr == `ADDR_STACK_SECOND;  // R10
  assign writeBottom    = writeStrobe && directAddr == `ADDR_STACK_BOTTOM;  // R10
  // The control register exists on page fifteen only.
  assign controlVisible = pageSel == PG_FIFTEEN;  // R5
  assign writeControl   = writeStrobe && directAddr == `ADDR_PAGE_CONTROL
                          && controlVisible;
  assign legalAccess    = sfrHit && bitAllowed;  // R2
  // Stack moves only on core events, and only while auto-paging is on.
  assign pushEvent      = vectorAccept && autoPageEnable;  // R14
  // Entry and return in one cycle keep the push, so the saved page is never lost.
  assign popEvent       = interruptReturnDone && autoPageEnable && !vectorAccept;  // R13

  ////////////////////////////////////////////////////////////////////////////////

  // A page write in the pop cycle loses to the stack move; in the push cycle it lands while the old page is pushed.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      activePageSelect <= `PAGE_RESET;  // R17
    end else if (popEvent) begin
      activePageSelect <= pageStackSecond_ff;  // R8 R19
    end else if (writePage) begin
      activePageSelect <= nxt_value;  // R18
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pageStackSecond_ff <= `PAGE_RESET;
    end else if (pushEvent) begin
      pageStackSecond_ff <= activePageSelect;  // R7 R19
    end else if (popEvent) begin
      pageStackSecond_ff <= pageStackBottom_ff;  // R9
    end else if (writeSecond) begin
      pageStackSecond_ff <= nxt_value;  // R10
    end
  end

  // The bottom empties to zero on pop so a deeper return finds no stale page.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pageStackBottom_ff <= `PAGE_RESET;
    end else if (pushEvent) begin
      pageStackBottom_ff <= pageStackSecond_ff;  // R7
    end else if (popEvent) begin
      pageStackBottom_ff <= `PAGE_ZERO;  // R9
    end else if (writeBottom) begin
      pageStackBottom_ff <= nxt_value;  // R10
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Only page fifteen reaches the enable; the upper seven bits have no storage.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      autoPageEnable <= ControlReset[`AUTO_ENABLE_BIT];  // R12
    end else if (writeControl) begin
      autoPageEnable <= nxt_value[`AUTO_ENABLE_BIT];  // R15
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Reads are answered from the address and page of the access edge.
  always_comb begin
    nxt_readData = 8'h00;
    if (sfrHit && !directWrite) begin
      if (all_page_reg(directAddr)) begin
        nxt_readData = currentValue;  // R16
      end else if (directAddr == `ADDR_PAGE_CONTROL && controlVisible) begin
        nxt_readData = {7'h00, autoPageEnable};  // R15
      end
    end
  end

  // Reads of anything this block does not own return zero, so the core can merge
  // the answers of all register owners with a plain OR.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      readData <= 8'h00;
    end else begin
      readData <= nxt_readData;  // R16
    end
  end

  // Select strobes are registered, so peripherals see them one cycle after the access.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sfrSelect         <= 1'b0;
      pageZeroSelect    <= 1'b0;
      pageTwoSelect     <= 1'b0;
      pageFifteenSelect <= 1'b0;
    end else begin
      sfrSelect         <= legalAccess;  // R1
      pageZeroSelect    <= legalAccess && pageSel == PG_ZERO;  // R4 R5
      pageTwoSelect     <= legalAccess && pageSel == PG_TWO;
      pageFifteenSelect <= legalAccess && pageSel == PG_FIFTEEN;
    end
  end

  // A refused bit access writes nothing; the flag lets the core report it.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      accessRefused <= 1'b0;
    end else begin
      accessRefused <= sfrHit && !bitAllowed;  // R2
    end
  end
endmodule : sfr_page_select_and_stack

/* dv/sfr_page_select_and_stack_properties.sv */
// Port checks for the paging block.
module sfr_page_checker import sfr_page_pkg::*; (
  input wire logic  mclk,
  input wire logic  rst_n,
  input wire logic  directAddrValid,
  input wire logic [7:0] directAddr,
  input wire logic  directWrite,
  input wire logic  bitAccess,
  input wire byte_t writeData,
  input wire logic  vectorAccept,
  input wire logic  interruptReturnDone,
  input wire byte_t readData,
  input wire logic  accessRefused,
  input wire logic  sfrSelect,
  input wire logic  pageZeroSelect,
  input wire logic  pageTwoSelect,
  input wire logic  pageFifteenSelect,
  input wire byte_t activePageSelect,
  input wire logic  autoPageEnable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire rd = directAddrValid && !directWrite && !bitAccess;
  wire pw = directAddrValid && directWrite && !bitAccess && directAddr == 8'ha7;
  wire ba = directAddrValid && bitAccess && directAddr[7];
  wire nib = directAddr[3:0] == 4'h0 || directAddr[3:0] == 4'h8;
  AST_PAGE_WR: assert property (pw && !vectorAccept && !interruptReturnDone
    |=> activePageSelect == $past(writeData)) else $error("page write lost");
  AST_PAGE_RD: assert property (rd && directAddr == 8'ha7
    |=> readData == $past(activePageSelect)) else $error("page read wrong");
  AST_PUSH_HOLD: assert property (vectorAccept && !pw
    |=> $stable(activePageSelect)) else $error("push moved page");
  AST_OFF_POP: assert property (interruptReturnDone && !autoPageEnable && !pw
    |=> $stable(activePageSelect)) else $error("pop while disabled");
  AST_CTRL_RD: assert property (rd && directAddr == 8'h8e && activePageSelect == 8'h0f
    |=> readData == {7'h00, $past(autoPageEnable)}) else $error("control read wrong");
  AST_CTRL_OFF: assert property (rd && directAddr == 8'h8e && activePageSelect != 8'h0f
    |=> readData == 8'h00) else $error("control seen off page");
  AST_REFUSE: assert property (ba && !nib |=> accessRefused)
    else $error("bit access not refused");
  AST_BIT_OK: assert property (ba && nib |=> !accessRefused)
    else $error("bit access refused");
  AST_LOW_RAM: assert property (rd && !directAddr[7] |=> readData == 8'h00)
    else $error("low address answered");
  AST_SELECT: assert property (directAddrValid && directAddr[7] && !bitAccess
    |=> sfrSelect) else $error("register access not selected");
  AST_SEL_ZERO: assert property (directAddrValid && directAddr[7] && !bitAccess
    && activePageSelect == 8'h00 |=> pageZeroSelect) else $error("page zero not selected");
  AST_SEL_TWO: assert property (directAddrValid && directAddr[7] && !bitAccess
    && activePageSelect == 8'h02 |=> pageTwoSelect) else $error("page two not selected");
  AST_SEL_NONE: assert property (directAddrValid && activePageSelect != 8'h00
    && activePageSelect != 8'h02 && activePageSelect != 8'h0f
    |=> !pageZeroSelect && !pageTwoSelect && !pageFifteenSelect)
    else $error("empty page selected");
endmodule : sfr_page_checker
bind sfr_page_select_and_stack sfr_page_checker sfr_page_checker_i (
  .mclk, .rst_n, .directAddrValid, .directAddr, .directWrite, .bitAccess,
  .writeData, .vectorAccept, .interruptReturnDone, .readData, .accessRefused,
  .sfrSelect, .pageZeroSelect, .pageTwoSelect, .pageFifteenSelect,
  .activePageSelect, .autoPageEnable
);

/* dv/sfr_core_model.sv */
// Behavioural core issuing direct accesses and interrupt events.
module sfr_core_model import sfr_page_pkg::*; (
  input wire logic mclk,
  output logic     directAddrValid,
  output byte_t    directAddr,
  output logic     directWrite,
  output logic     bitAccess,
  output logic [2:0] bitIndex,
  output logic     bitValue,
  output byte_t    writeData,
  output logic     vectorAccept,
  output logic     interruptReturnDone
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {directAddrValid, directWrite, bitAccess, bitValue} = 4'h0;
    {vectorAccept, interruptReturnDone, bitIndex} = 5'h00;
    directAddr = 8'h00;
    writeData = 8'h00;
  end
  // Unoccupied locations too: control on page zero, and bit 0x80 on page 0x22 left by a pop.
  task acc(input logic w, input logic b, input byte_t a, input byte_t d);
    @(posedge mclk) #1;
    directAddrValid = 1'b1;
    {directWrite, bitAccess, directAddr, writeData} = {w, b, a, d};
    {bitIndex, bitValue} = d[3:0];
    @(posedge mclk) #1;
    directAddrValid = 1'b0;
    // Released lines turn over so a stale value cannot pass.
    directAddr = ~a;
    writeData = ~d;
  endtask : acc
  task ev(input logic r);
    @(posedge mclk) #1;
    {vectorAccept, interruptReturnDone} = {!r, r};
    @(posedge mclk) #1;
    {vectorAccept, interruptReturnDone} = 2'b00;
  endtask : ev
endmodule : sfr_core_model

/* dv/sfr_page_select_and_stack_test.sv */
// Directed tests of page selection and the page stack.
module sfr_page_select_and_stack_test;
  timeunit 1ns;
  timeprecision 1ns;
  import sfr_page_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic directAddrValid, directWrite, bitAccess, bitValue, vectorAccept;
  logic interruptReturnDone, sfrSelect, accessRefused, autoPageEnable;
  logic pageZeroSelect, pageTwoSelect, pageFifteenSelect;
  logic [2:0] bitIndex;
  byte_t directAddr, writeData, readData, activePageSelect;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  sfr_core_model sfr_core_model_i (.mclk, .directAddrValid, .directAddr,
    .directWrite, .bitAccess, .bitIndex, .bitValue, .writeData, .vectorAccept,
    .interruptReturnDone);
  sfr_page_select_and_stack sfr_page_select_and_stack_i (.mclk, .rst_n,
    .directAddrValid, .directAddr, .directWrite, .bitAccess, .bitIndex,
    .bitValue, .writeData, .vectorAccept, .interruptReturnDone, .readData,
    .sfrSelect, .pageZeroSelect, .pageTwoSelect, .pageFifteenSelect,
    .accessRefused, .activePageSelect, .autoPageEnable);
  initial forever #50 mclk = ~mclk;
  task complete_run;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      n_fail++;
      complete_run();
    end
  end
  task chk(input string n, input byte_t e, input byte_t g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task rd(input byte_t a, input string n, input byte_t e);
    sfr_core_model_i.acc(1'b0, 1'b0, a, 8'h00);
    chk(n, e, readData);
  endtask : rd
  task wr(input byte_t a, input byte_t d);
    sfr_core_model_i.acc(1'b1, 1'b0, a, d);
  endtask : wr
  initial begin
    repeat (12) @(posedge mclk);
    #1 rst_n = 1'b1;
    chk("enable", 8'h01, {7'h00, autoPageEnable});
    rd(8'ha7, "page", 8'h00);
    rd(8'h85, "second", 8'h00);
    rd(8'h86, "bottom", 8'h00);
    chk("select", 8'h01, {7'h00, sfrSelect});
    chk("zero", 8'h01, {7'h00, pageZeroSelect});
    $display("end reset");
    wr(8'ha7, 8'h0f);
    rd(8'h8e, "control", 8'h01);
    chk("fifteen", 8'h01, {7'h00, pageFifteenSelect});
    wr(8'h8e, 8'hfe);
    rd(8'h8e, "control", 8'h00);
    sfr_core_model_i.ev(1'b0);
    rd(8'h85, "second", 8'h00);
    wr(8'h85, 8'h44);
    sfr_core_model_i.ev(1'b1);
    rd(8'ha7, "page", 8'h0f);
    rd(8'h85, "second", 8'h44);
    wr(8'h8e, 8'h01);
    wr(8'ha7, 8'h00);
    rd(8'h8e, "control", 8'h00);
    $display("end control");
    wr(8'ha7, 8'h0f);
    wr(8'h86, 8'h33);
    wr(8'h85, 8'h22);
    rd(8'ha7, "page", 8'h0f);
    sfr_core_model_i.ev(1'b0);
    rd(8'h85, "second", 8'h0f);
    rd(8'h86, "bottom", 8'h22);
    wr(8'ha7, 8'h02);
    rd(8'ha7, "page", 8'h02);
    chk("two", 8'h01, {7'h00, pageTwoSelect});
    sfr_core_model_i.ev(1'b1);
    chk("page", 8'h0f, activePageSelect);
    rd(8'h85, "second", 8'h22);
    rd(8'h86, "bottom", 8'h00);
    sfr_core_model_i.ev(1'b1);
    rd(8'ha7, "page", 8'h22);
    chk("zero", 8'h00, {7'h00, pageZeroSelect});
    $display("end stack");
    rd(8'h40, "low", 8'h00);
    chk("select", 8'h00, {7'h00, sfrSelect});
    sfr_core_model_i.acc(1'b1, 1'b1, 8'h85, 8'hff);
    chk("refused", 8'h01, {7'h00, accessRefused});
    rd(8'h85, "second", 8'h00);
    sfr_core_model_i.acc(1'b0, 1'b1, 8'h80, 8'h00);
    chk("refused", 8'h00, {7'h00, accessRefused});
    $display("end decode");
    complete_run();
  end
endmodule : sfr_page_select_and_stack_test
